// file: rtl/otpcp_pkg.sv
// Package with constants for the code protection block
package otpcp_pkg;
    localparam int CODE_AW = 13;
    localparam int CODE_DEPTH = 8192;
    localparam int ENC_AW = 6;
    localparam int ENC_DEPTH = 64;
    localparam int SIG_AW = 2;
    localparam int SIG_DEPTH = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] CONFIG_RESET = 8'hFF;
    localparam logic [7:0] REG_CONFIG_OFFSET = 8'hEF;
    localparam logic [7:0] REG_STATUS_OFFSET = 8'hF0;
    localparam logic [7:0] REG_CONFIG_RAW_OFFSET = 8'hF1;
    localparam int LOCK_TWO_POS = 7;
    localparam int LOCK_THREE_POS = 6;
    localparam int LOCK_FOUR_POS = 5;
    localparam logic [4:0] RESERVED_ONES = 5'h1F;
    localparam logic [31:0] SIGNATURE_WORD = 32'h5A5A_A5A5; // Arbitrary value
    typedef enum logic [1:0] {OP_NONE, OP_PROG_CODE, OP_PROG_ENC, OP_PROG_SECURITY_CONFIG_BYTE} otpcp_op_t;
    typedef enum logic [1:0] {RD_VERIFY, RD_SIGNATURE, RD_SECURITY_CONFIG_BYTE, RD_NONE} otpcp_rd_t;
endpackage

// file: rtl/otpcp_top.sv
// Program memory protection: code, encryption and signature arrays with lock levels
// Summary of operation
// - Code array of 8K bytes, byte addressed for program, verify and fetch.
// - Encryption array of 64 bytes, all bits one until programmed.
// - Four signature bytes fixed at build, read only.
// - Verify uses six low address bits to select the encryption byte.
// - Verify output is XNOR of code byte and encryption byte.
// - Erased encryption entry returns code byte unchanged.
// - Level one: no locks, verify still encrypted, table reads unencrypted.
// - Level two: block external table reads, latch access input, no code or encryption programming.
// - Level three: level two plus verify inhibited.
// - Level four: level three plus no external execution.
// - Lock bits sit in config bits 7..5; low five bits stay one.
// - Mask build fixes config byte; OTP build lets programmer write it.
// - Software reads config byte read only; writes ignored.
// - After reset config reads ones in bits 7..0 when unlocked.
`timescale 1ns/1ps
`default_nettype none
module otpcp_top
    import otpcp_pkg::*;
#(
    parameter bit MASK_VERSION = 1'b0,
    parameter logic [7:0] MASK_CONFIG = 8'hFF
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // Programmer side, from pins
    input wire logic prog_strobe,
    input wire otpcp_op_t prog_op,
    input wire logic [CODE_AW-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic rd_strobe,
    input wire otpcp_rd_t rd_sel,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_refused,
    output logic prog_refused,
    // CPU side, same clock
    input wire logic fetch_req,
    input wire logic fetch_is_table_read,
    input wire logic fetch_from_external,
    input wire logic [CODE_AW-1:0] fetch_addr,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    output logic fetch_blocked,
    input wire logic external_access_input,
    output logic ext_access_latched,
    output logic ext_exec_disable,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response
);
    import otpcp_pkg::*;

    // Arrays; encryption and config held in flops so reset models the erased state
    logic [7:0] code_mem [CODE_DEPTH];
    logic [7:0] enc_q [ENC_DEPTH];
    logic [7:0] enc_d [ENC_DEPTH];
    logic [7:0] security_config_byte_q, security_config_byte_d;
    // Pin synchronisers, two stages before any use
    logic ps_s1_q, ps_s2_q, ps_s3_q;
    logic rs_s1_q, rs_s2_q, rs_s3_q;
    logic ea_s1_q, ea_s2_q;
    otpcp_op_t op_s1_q, op_s2_q;
    otpcp_rd_t rs1_q, rs2_q;
    logic [CODE_AW-1:0] pa_s1_q, pa_s2_q;
    logic [7:0] pd_s1_q, pd_s2_q;
    logic [7:0] rd_data_q, rd_data_d, fetch_data_q, fetch_data_d;
    logic rd_valid_q, rd_valid_d, rd_ref_q, rd_ref_d, pr_ref_q, pr_ref_d;
    logic fv_q, fv_d, fb_q, fb_d;
    logic ea_lat_q, ea_lat_d, ea_done_q, ea_done_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic [1:0] resp_q, resp_d;
    logic prog_pulse, rd_pulse;
    logic lvl2, lvl3, lvl4;
    // Highest programmed lock bit wins; a programmed bit reads as zero
    function automatic logic [2:0] lock_levels(input logic [7:0] c);
        logic two, three, four;
        four = ~c[LOCK_FOUR_POS];
        three = ~c[LOCK_THREE_POS] | four;
        two = ~c[LOCK_TWO_POS] | three;
        return {four, three, two};
    endfunction
    // Signature byte lookup, constant content
    function automatic logic [7:0] sig_byte(input logic [SIG_AW-1:0] a);
        return SIGNATURE_WORD[{a, 3'b000} +: 8];
    endfunction

    assign {lvl4, lvl3, lvl2} = lock_levels(security_config_byte_q);
    assign prog_pulse = ps_s2_q & ~ps_s3_q;
    assign rd_pulse = rs_s2_q & ~rs_s3_q;

    // Synchroniser registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ps_s1_q <= 1'b0;
            ps_s2_q <= 1'b0;
            ps_s3_q <= 1'b0;
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
            rs_s3_q <= 1'b0;
            op_s1_q <= OP_NONE;
            op_s2_q <= OP_NONE;
            rs1_q <= RD_NONE;
            rs2_q <= RD_NONE;
            pa_s1_q <= '0;
            pa_s2_q <= '0;
            pd_s1_q <= 8'h00;
            pd_s2_q <= 8'h00;
        end
        else if (clk_en)
        begin
            ps_s1_q <= prog_strobe;
            ps_s2_q <= ps_s1_q;
            ps_s3_q <= ps_s2_q;
            rs_s1_q <= rd_strobe;
            rs_s2_q <= rs_s1_q;
            rs_s3_q <= rs_s2_q;
            op_s1_q <= prog_op;
            op_s2_q <= op_s1_q;
            rs1_q <= rd_sel;
            rs2_q <= rs1_q;
            pa_s1_q <= prog_addr;
            pa_s2_q <= pa_s1_q;
            pd_s1_q <= prog_data;
            pd_s2_q <= pd_s1_q;
        end
    end

    // Code write and access pin sync, no reset: the pin is sampled while reset is held
    // Cells start unknown here, so a write stores the byte whole instead of clearing bits
    always_ff @(posedge clock)
    begin
        if (clk_en)
        begin
            ea_s1_q <= external_access_input;
            ea_s2_q <= ea_s1_q;
            if (prog_pulse && op_s2_q == OP_PROG_CODE && !lvl2)
            begin
                code_mem[pa_s2_q] <= pd_s2_q;
            end
        end
    end

    // Programming of encryption array and config byte; cells only clear bits
    always_comb
    begin
        security_config_byte_d = security_config_byte_q;
        pr_ref_d = 1'b0;
        for (int i = 0; i < ENC_DEPTH; i++)
        begin
            enc_d[i] = enc_q[i];
        end
        if (prog_pulse && op_s2_q != OP_NONE)
        begin
            if (lvl2 && op_s2_q != OP_PROG_SECURITY_CONFIG_BYTE)
            begin
                pr_ref_d = 1'b1;
            end
            else if (op_s2_q == OP_PROG_ENC)
            begin
                enc_d[pa_s2_q[ENC_AW-1:0]] = enc_q[pa_s2_q[ENC_AW-1:0]] & pd_s2_q;
            end
            else if (op_s2_q == OP_PROG_SECURITY_CONFIG_BYTE)
            begin
                if (MASK_VERSION)
                begin
                    pr_ref_d = 1'b1;
                end
                else
                begin
                    // Only lock bits may be programmed; reserved bits held at one
                    security_config_byte_d = {security_config_byte_q[7:5] & pd_s2_q[7:5], RESERVED_ONES};
                end
            end
        end
    end

    // Erased state at reset is a modelling shortcut for the OTP cells
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            security_config_byte_q <= CONFIG_RESET;
            pr_ref_q <= 1'b0;
            for (int i = 0; i < ENC_DEPTH; i++)
            begin
                enc_q[i] <= ERASED_BYTE;
            end
        end
        else if (clk_en)
        begin
            security_config_byte_q <= MASK_VERSION ? {MASK_CONFIG[7:5], RESERVED_ONES} : security_config_byte_d;
            pr_ref_q <= pr_ref_d;
            for (int i = 0; i < ENC_DEPTH; i++)
            begin
                enc_q[i] <= enc_d[i];
            end
        end
    end

    // Programmer reads: verify, signature, config
    always_comb
    begin
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        rd_ref_d = 1'b0;
        if (rd_pulse)
        begin
            case (rs2_q)
                RD_VERIFY:
                begin
                    if (lvl3)
                    begin
                        rd_ref_d = 1'b1;
                        rd_data_d = 8'h00;
                    end
                    else
                    begin
                        rd_valid_d = 1'b1;
                        // Erased entry of all ones passes code through
                        rd_data_d = ~(code_mem[pa_s2_q] ^ enc_q[pa_s2_q[ENC_AW-1:0]]);
                    end
                end
                RD_SIGNATURE:
                begin
                    rd_valid_d = 1'b1;
                    rd_data_d = sig_byte(pa_s2_q[SIG_AW-1:0]);
                end
                RD_SECURITY_CONFIG_BYTE:
                begin
                    rd_valid_d = 1'b1;
                    rd_data_d = security_config_byte_q;
                end
                default:
                begin
                    rd_ref_d = 1'b1;
                end
            endcase
        end
    end

    // CPU fetch path and access input latch
    always_comb
    begin
        fetch_data_d = fetch_data_q;
        fv_d = 1'b0;
        fb_d = 1'b0;
        ea_lat_d = ea_lat_q;
        ea_done_d = ea_done_q;
        if (!ea_done_q)
        begin
            // First enabled cycle after reset release captures the pin
            ea_lat_d = ea_s2_q;
            ea_done_d = 1'b1;
        end
        if (fetch_req)
        begin
            if ((fetch_is_table_read && fetch_from_external && lvl2) ||
                (fetch_from_external && lvl4))
            begin
                fb_d = 1'b1;
                fetch_data_d = 8'h00;
            end
            else
            begin
                fv_d = 1'b1;
                fetch_data_d = code_mem[fetch_addr];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            rd_ref_q <= 1'b0;
            fetch_data_q <= 8'h00;
            fv_q <= 1'b0;
            fb_q <= 1'b0;
            ea_lat_q <= 1'b0;
            ea_done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_ref_q <= rd_ref_d;
            fetch_data_q <= fetch_data_d;
            fv_q <= fv_d;
            fb_q <= fb_d;
            ea_lat_q <= ea_lat_d;
            ea_done_q <= ea_done_d;
        end
    end

    // Avalon slave: one wait cycle, answer registered
    always_comb
    begin
        ack_d = 1'b0;
        rdata_d = rdata_q;
        resp_d = 2'b00;
        if ((avs_read || avs_write) && !ack_q)
        begin
            ack_d = 1'b1;
            rdata_d = 32'h0000_0000;
            case (avs_address)
                REG_CONFIG_OFFSET:
                begin
                    // Writes fall away here; the byte is read only to software
                    rdata_d = {24'h00_0000, security_config_byte_q};
                end
                REG_STATUS_OFFSET:
                begin
                    rdata_d = {24'h00_0000, 4'h0, ea_lat_q, lvl4, lvl3, lvl2};
                end
                default:
                begin
                    resp_d = 2'b11; // Unmapped: decode error
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'b00;
        end
        else if (clk_en)
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rd_refused = rd_ref_q;
    assign prog_refused = pr_ref_q;
    assign fetch_data = fetch_data_q;
    assign fetch_valid = fv_q;
    assign fetch_blocked = fb_q;
    assign ext_access_latched = ea_lat_q;
    assign ext_exec_disable = lvl4;
endmodule
`default_nettype wire

// file: verification/otpcp_top_assertions.sv
// Port-level assertions for the code protection block
`timescale 1ns/1ps
`default_nettype none
module otpcp_top_chk
    import otpcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic fetch_req,
    input wire logic fetch_from_external,
    input wire logic [7:0] fetch_data,
    input wire logic fetch_valid,
    input wire logic fetch_blocked,
    input wire logic ext_exec_disable,
    input wire logic rd_strobe,
    input wire logic rd_valid,
    input wire logic rd_refused,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response
);
    // Accepted bus reads, split by decode
    wire logic bus_rd = avs_read && !avs_waitrequest;
    wire logic security_config_byte_rd = bus_rd && avs_address == REG_CONFIG_OFFSET;
    wire logic odd_rd = bus_rd && avs_address != REG_CONFIG_OFFSET
        && avs_address != REG_STATUS_OFFSET && avs_address != REG_CONFIG_RAW_OFFSET;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    a_one_wait: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer timing wrong");
    a_security_config_byte_layout: assert property (security_config_byte_rd |-> avs_response == 2'h0
        && avs_readdata[31:8] == 24'h0 && avs_readdata[4:0] == RESERVED_ONES)
        else $error("config read layout wrong");
    a_exec_tie: assert property (security_config_byte_rd |->
        avs_readdata[LOCK_FOUR_POS] == !ext_exec_disable) else $error("exec disable mismatch");
    a_unmapped_err: assert property (odd_rd |->
        avs_response == 2'h3 && avs_readdata == 32'h0) else $error("unmapped read not refused");
    a_fetch_answer: assert property (fetch_req && clk_en |=>
        fetch_valid != fetch_blocked) else $error("fetch answer missing");
    a_ext_blocked: assert property (fetch_req && fetch_from_external && ext_exec_disable
        && clk_en |=> fetch_blocked && fetch_data == 8'h00) else $error("external fetch ran");
    a_rd_answer: assert property ($rose(rd_strobe) |->
        ##[2:6] (rd_valid || rd_refused)) else $error("read strobe not answered");
    a_refused_zero: assert property (rd_refused |->
        rd_data == 8'h00 && !rd_valid) else $error("refused read leaked data");
    // Enable low must hold fetch and read data and valid outputs where they stand
    a_freeze_hold: assert property (!clk_en |=> $stable(fetch_data) && $stable(rd_data)
        && $stable(fetch_valid) && $stable(rd_valid)) else $error("outputs moved while frozen");
endmodule
bind otpcp_top otpcp_top_chk i_otpcp_top_chk (.*);
`default_nettype wire

// file: verification/otpcp_prog_model.sv
// Parallel programmer model driving the strobe pins
`timescale 1ns/1ps
`default_nettype none
module otpcp_prog_model
    import otpcp_pkg::*;
(
    input wire logic clock,
    output logic prog_strobe,
    output otpcp_op_t prog_op,
    output logic [CODE_AW-1:0] prog_addr,
    output logic [7:0] prog_data,
    output logic rd_strobe,
    output otpcp_rd_t rd_sel
);
    // Idle pins at time zero
    initial
    begin
        prog_strobe = 1'b0;
        rd_strobe = 1'b0;
        prog_op = OP_NONE;
        rd_sel = RD_NONE;
        prog_addr = '0;
        prog_data = 8'hFF;
    end
    // Address and mode settle well before the strobe, since the pin path is synchronised
    task automatic xfer(input logic rd, input logic [1:0] code, input logic [CODE_AW-1:0] ad,
        input logic [7:0] dt);
        @(posedge clock);
        prog_addr <= ad;
        prog_data <= dt;
        prog_op <= otpcp_op_t'(rd ? 2'h0 : code);
        rd_sel <= otpcp_rd_t'(rd ? code : 2'h3);
        repeat (4) @(posedge clock);
        rd_strobe <= rd;
        prog_strobe <= !rd;
        repeat (6) @(posedge clock);
        rd_strobe <= 1'b0;
        prog_strobe <= 1'b0;
        repeat (5) @(posedge clock);
        prog_data <= ~dt; // Released lines do not keep the last value
    endtask
endmodule
`default_nettype wire

// file: verification/otpcp_top_tb.sv
// Self-checking bench for the code protection block
`timescale 1ns/1ps
`default_nettype none
module otpcp_top_tb;
    import otpcp_pkg::*;
    otpcp_op_t prog_op;
    otpcp_rd_t rd_sel;
    logic clock, rst_b, clk_en, prog_strobe, rd_strobe, rd_valid, rd_refused, prog_refused;
    logic fetch_req, fetch_is_table_read, fetch_from_external, fetch_valid, fetch_blocked;
    logic external_access_input, ext_access_latched, ext_exec_disable;
    logic avs_read, avs_write, avs_waitrequest;
    logic [CODE_AW-1:0] prog_addr, fetch_addr, a;
    logic [7:0] prog_data, rd_data, fetch_data, avs_address, d, e;
    logic [31:0] avs_writedata, avs_readdata, r;
    logic [3:0] avs_byteenable;
    logic [1:0] avs_response;
    logic [35:0] expq[$];
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 33;
    otpcp_top i_otpcp_top (.*);
    otpcp_prog_model i_otpcp_prog_model (.*);
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic finish_test;
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A result with no note left is flagged by an impossible kind code
    task automatic take(input logic [35:0] seen);
        if (expq.size() == 0)
            chk(seen, {4'hE, 32'h0});
        else
            chk(seen, expq.pop_front());
    endtask
    // Monitor: every result pulse or accepted bus read consumes the oldest note
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fails++;
            finish_test;
        end
        if (rd_valid === 1'b1 || rd_refused === 1'b1)
            take({4'h1, 22'h0, rd_refused, rd_valid, rd_data});
        if (fetch_valid === 1'b1 || fetch_blocked === 1'b1)
            take({4'h2, 22'h0, fetch_blocked, fetch_valid, fetch_data});
        if (prog_refused === 1'b1)
            take({4'h3, 32'h0});
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            take({2'h0, avs_response, avs_readdata});
    end
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [35:0] ex);
        if (!wr)
            expq.push_back(ex);
        @(posedge clock);
        avs_address <= ad;
        avs_writedata <= 32'h0;
        avs_read <= !wr;
        avs_write <= wr;
        // Wait for the answer however long; a hang ends at the bench timeout
        do
        begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdx(input logic [1:0] sel, input logic [CODE_AW-1:0] ad, input logic [9:0] res);
        expq.push_back({4'h1, 22'h0, res});
        i_otpcp_prog_model.xfer(1'b1, sel, ad, 8'h00);
    endtask
    task automatic pg(input logic [1:0] op, input logic [CODE_AW-1:0] ad, input logic [7:0] dt,
        input logic refused);
        if (refused)
            expq.push_back({4'h3, 32'h0});
        i_otpcp_prog_model.xfer(1'b0, op, ad, dt);
    endtask
    // One fetch cycle; the answer is due at the next edge
    task automatic fx(input logic tbl, input logic ext, input logic [CODE_AW-1:0] ad,
        input logic [9:0] res);
        expq.push_back({4'h2, 22'h0, res});
        @(posedge clock);
        fetch_req <= 1'b1;
        fetch_is_table_read <= tbl;
        fetch_from_external <= ext;
        fetch_addr <= ad;
        @(posedge clock);
        fetch_req <= 1'b0;
    endtask
    task automatic reset_dut;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
    endtask
    initial
    begin
        r = $random(seed);
        external_access_input = r[31];
        rst_b = 1'b0;
        clk_en = 1'b1;
        fetch_req = 1'b0;
        fetch_is_table_read = 1'b0;
        fetch_from_external = 1'b0;
        fetch_addr = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        reset_dut;
        bus(1'b0, REG_CONFIG_OFFSET, {28'h0, CONFIG_RESET});
        bus(1'b1, REG_CONFIG_OFFSET, 36'h0);
        bus(1'b0, REG_CONFIG_OFFSET, {28'h0, CONFIG_RESET});
        bus(1'b0, 8'h10, {4'h3, 32'h0});
        for (int i = 0; i < 4; i++)
            rdx(RD_SIGNATURE, CODE_AW'(i), {2'b01, SIGNATURE_WORD[8*i +: 8]});
        r = $random(seed);
        {a, d, e} = r[28:0];
        pg(OP_PROG_CODE, a, d, 1'b0);
        pg(OP_PROG_CODE, a ^ 13'h40, ~d, 1'b0);
        pg(OP_PROG_CODE, a ^ 13'h20, d, 1'b0);
        rdx(RD_VERIFY, a, {2'b01, d});
        pg(OP_PROG_ENC, a, e, 1'b0);
        rdx(RD_VERIFY, a, {2'b01, ~(d ^ e)});
        rdx(RD_VERIFY, a ^ 13'h40, {2'b01, d ^ e});
        rdx(RD_VERIFY, a ^ 13'h20, {2'b01, d});
        fx(1'b1, 1'b1, a, {2'b01, d});
        pg(OP_PROG_SECURITY_CONFIG_BYTE, '0, 8'h7F, 1'b0);
        bus(1'b0, REG_CONFIG_OFFSET, {28'h0, 8'h7F});
        fx(1'b1, 1'b1, a, {2'b10, 8'h00});
        fx(1'b1, 1'b0, a, {2'b01, d});
        pg(OP_PROG_CODE, a, 8'h00, 1'b1);
        pg(OP_PROG_ENC, a, 8'h00, 1'b1);
        rdx(RD_VERIFY, a, {2'b01, ~(d ^ e)});
        pg(OP_PROG_SECURITY_CONFIG_BYTE, '0, 8'hA0, 1'b0);
        rdx(RD_SECURITY_CONFIG_BYTE, '0, {2'b01, 8'h3F});
        rdx(RD_VERIFY, a, {2'b10, 8'h00});
        pg(OP_PROG_SECURITY_CONFIG_BYTE, '0, 8'hDF, 1'b0);
        bus(1'b0, REG_STATUS_OFFSET, {28'h0, 4'h0, external_access_input, 3'h7});
        chk({34'h0, ext_access_latched, ext_exec_disable}, {34'h0, external_access_input, 1'b1});
        fx(1'b0, 1'b1, a, {2'b10, 8'h00});
        fx(1'b0, 1'b0, a, {2'b01, d});
        reset_dut;
        rdx(RD_VERIFY, a, {2'b01, d});
        pg(OP_PROG_SECURITY_CONFIG_BYTE, '0, 8'hDF, 1'b0);
        rdx(RD_VERIFY, a, {2'b10, 8'h00});
        fx(1'b1, 1'b1, a, {2'b10, 8'h00});
        // Frozen edge: a fetch seen only while the enable is low must get no answer
        @(posedge clock);
        clk_en <= 1'b0;
        fetch_req <= 1'b1;
        @(posedge clock);
        clk_en <= 1'b1;
        fetch_req <= 1'b0;
        repeat (10) @(posedge clock);
        chk(36'(expq.size()), 36'h0);
        finish_test;
    end
endmodule
`default_nettype wire
